// File: design/arr_device.sv
// converter end: result buffer, parallel and serial readout of results
`timescale 1ns/1ps
`include "arr_consts.svh"

// converter end of the link
module arr_device (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [15:0] conv_data, // sampled input value, straight binary
  output logic conv_busy, // copy of the busy pin
  arr_link_if.dev link
);
  arr_pkg::arr_dev_s s; // registered state
  arr_pkg::arr_dev_s next_s; // next state
  logic fifo_in_valid; // finished conversion offered to the buffer
  logic fifo_in_ready; // buffer has room
  logic fifo_out_valid; // buffered result waiting
  logic fifo_out_ready; // readout takes a result
  logic [15:0] fifo_out_data; // oldest buffered result
  logic fifo_clear; // buffer emptied on reset release
  logic [15:0] coded; // sample in the selected coding
  logic rst_rise;
  logic rst_fall;
  logic cnv_fall;
  logic serial;
  logic master;
  logic eclk;
  logic cclk;
  logic drive;
  logic [7:0] half;
  logic [15:0] w;

  arr_fifo #(.WIDTH(`ARR_RES_BITS), .DEPTH(`ARR_FIFO_DEPTH)) arr_fifo_inst (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clear(fifo_clear),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(coded),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  assign conv_busy = s.busy;
  assign link.busy = s.busy;
  assign link.dev_d = s.dout;
  assign link.dev_oe = s.doe;

  // next state of the whole converter end
  always_comb begin
    next_s = s;
    next_s.rderr = 1'b0;
    fifo_in_valid = 1'b0;
    fifo_out_ready = 1'b0;
    rst_rise = ~s.rst_prev & link.converter_reset;
    rst_fall = s.rst_prev & ~link.converter_reset;
    cnv_fall = s.cnv_prev & ~link.convert_start_n;
    fifo_clear = rst_fall;
    next_s.rst_prev = link.converter_reset;
    next_s.cnv_prev = link.convert_start_n;
    serial = link.interface_type_select;
    master = serial & ~link.clock_source_select;
    // straight binary or twos complement output
    if (link.output_coding_select | (serial & s.cfg[`ARR_CFG_CODING_BIT])) begin
      coded = s.sample;
    end else begin
      coded = {~s.sample[15], s.sample[14:0]};
    end
    // clock period: divider after convert, two periods during convert
    if (link.read_timing_select) begin
      half = (s.bitcnt >= 5'(`ARR_RES_BITS - `ARR_RDC_SLOW_BITS)) ?
             8'(2 * `ARR_HALF_BASE) : 8'(`ARR_HALF_BASE);
    end else begin
      half = 8'(`ARR_HALF_BASE) * ({6'h00, link.clock_divider_select} + 8'h01);
    end
    // conversion sequence
    case (s.cstate)
      arr_pkg::ARR_IDLE: begin
        // start is independent of select and read
        if (cnv_fall & ~link.converter_reset) begin
          next_s.cstate = arr_pkg::ARR_CONV;
          next_s.ccnt = 8'h00;
          next_s.sample = conv_data;
          next_s.busy = 1'b1;
          // previous result goes out during this conversion
          if (master & link.read_timing_select & ~s.shifting) begin
            next_s.shreg = s.out_word;
            next_s.bitcnt = 5'h00;
            next_s.shifting = 1'b1;
            next_s.hcnt = 8'h00;
            next_s.sclk = 1'b0;
          end
        end
      end
      arr_pkg::ARR_CONV: begin
        next_s.ccnt = s.ccnt + 8'h01;
        if (s.ccnt == 8'(`ARR_CONV_CYCLES - 1)) begin
          next_s.cstate = arr_pkg::ARR_PUSH;
        end
      end
      arr_pkg::ARR_PUSH: begin
        // full buffer holds the converter here with busy high
        fifo_in_valid = 1'b1;
        if (fifo_in_ready) begin
          next_s.cstate = arr_pkg::ARR_IDLE;
          // master after-convert keeps busy until shifted
          if (!(master & ~link.read_timing_select)) begin
            next_s.busy = 1'b0;
          end
          // read during conversion left unfinished
          if (serial & ~master & link.read_timing_select &&
              s.bitcnt != 5'h00 && s.bitcnt != 5'(`ARR_RES_BITS)) begin
            next_s.rderr = 1'b1;
            next_s.bitcnt = 5'(`ARR_RES_BITS); // abandoned read lets the new word load
          end
        end
      end
      default: next_s.cstate = arr_pkg::ARR_IDLE;
    endcase
    // take the next result when no frame is under way
    if (fifo_out_valid & ~s.shifting &
        (master | s.bitcnt == 5'h00 | s.bitcnt == 5'(`ARR_RES_BITS))) begin
      fifo_out_ready = 1'b1;
      next_s.out_word = fifo_out_data;
      next_s.shreg = fifo_out_data;
      next_s.bitcnt = 5'h00;
      // after-convert master frame starts at once
      if (master & ~link.read_timing_select) begin
        next_s.shifting = 1'b1;
        next_s.hcnt = 8'h00;
        next_s.sclk = 1'b0;
      end
    end
    // internal clock: data changes on the falling edge only
    if (s.shifting) begin
      if (s.hcnt == half - 8'h01) begin
        next_s.hcnt = 8'h00;
        next_s.sclk = ~s.sclk;
        if (s.sclk) begin
          next_s.shreg = {s.shreg[14:0], 1'b0};
          next_s.bitcnt = s.bitcnt + 5'h01;
          if (s.bitcnt == 5'(`ARR_RES_BITS - 1)) begin
            next_s.shifting = 1'b0; // discontinuous clock stops
            if (~link.read_timing_select && s.cstate == arr_pkg::ARR_IDLE) begin
              next_s.busy = 1'b0;
            end
          end
        end
      end else begin
        next_s.hcnt = s.hcnt + 8'h01;
      end
    end
    // external clock, normalised so either idle level works
    eclk = link.bus[`ARR_PIN_SCLK] ^ link.clock_polarity_invert;
    next_s.ext_prev = eclk;
    if (serial & ~master & ~link.cs_n & ~link.rd_n) begin
      if (eclk & ~s.ext_prev && s.bitcnt != 5'(`ARR_RES_BITS)) begin
        next_s.bitcnt = s.bitcnt + 5'h01;
      end
      if (~eclk & s.ext_prev && s.bitcnt != 5'h00 && s.bitcnt != 5'(`ARR_RES_BITS)) begin
        next_s.shreg = {s.shreg[14:0], 1'b0};
      end
    end
    // configuration port on the upper data pins, serial mode only
    cclk = link.bus[`ARR_PIN_CFG_CLK] ^ link.clock_polarity_invert;
    next_s.cfg_clk_prev = cclk;
    if (!serial || link.bus[`ARR_PIN_CFG_CS]) begin
      next_s.cfg_cnt = 4'h0;
    end else if (cclk & ~s.cfg_clk_prev) begin
      next_s.cfg_sh = {s.cfg_sh[7:0], link.bus[`ARR_PIN_CFG_DIN]};
      next_s.cfg_cnt = s.cfg_cnt + 4'h1;
      if (s.cfg_cnt == 4'(`ARR_CFG_BITS - 1)) begin
        next_s.cfg_cnt = 4'h0;
        if (s.cfg_sh[`ARR_CFG_START_BIT - 1]) begin
          next_s.cfg = {s.cfg_sh[7:0], link.bus[`ARR_PIN_CFG_DIN]};
        end
      end
    end
    // reset pin: rise aborts, fall clears
    if (rst_rise | link.converter_reset) begin
      next_s.cstate = arr_pkg::ARR_IDLE;
      next_s.busy = 1'b0;
      next_s.shifting = 1'b0;
    end
    if (rst_fall) begin
      next_s.out_word = 16'h0000;
      next_s.shreg = 16'h0000;
      next_s.bitcnt = 5'h00;
      next_s.cfg = 9'h000;
      next_s.cfg_cnt = 4'h0;
    end
    // pin drive: floats unless selected and read, and out of reset
    drive = ~link.cs_n & ~link.rd_n & ~link.converter_reset;
    w = next_s.out_word;
    next_s.dout = 16'h0000;
    next_s.doe = 16'h0000;
    if (drive & ~serial) begin
      // parallel; always driven when the host ties both low outside converter reset
      next_s.dout = link.byte_order_select ? {w[7:0], w[15:8]} : w;
      next_s.doe = 16'hFFFF;
    end else if (drive) begin
      // serial signals on the data pins
      next_s.dout[`ARR_PIN_SERIAL_RESULT_OUT] = next_s.shreg[15];
      next_s.dout[`ARR_PIN_RDERR] = next_s.rderr;
      next_s.doe[`ARR_PIN_SERIAL_RESULT_OUT] = 1'b1;
      next_s.doe[`ARR_PIN_RDERR] = 1'b1;
      if (master) begin
        next_s.dout[`ARR_PIN_SCLK] = next_s.sclk ^ link.clock_polarity_invert;
        next_s.dout[`ARR_PIN_SYNC] = next_s.shifting ^ link.frame_polarity_invert;
        next_s.doe[`ARR_PIN_SCLK] = 1'b1;
        next_s.doe[`ARR_PIN_SYNC] = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.cnv_prev <= 1'b1;
      s.cstate <= arr_pkg::ARR_IDLE;
    end else begin
      s <= next_s;
    end
  end
endmodule // arr_device

// File: shared/arr_consts.svh
// timing counts, pin positions and field layouts of the result readout link
`ifndef ARR_CONSTS_SVH
`define ARR_CONSTS_SVH
`define ARR_CLK_PERIOD_NS 10
`define ARR_CONV_TIME_NS 1450
`define ARR_CONV_CYCLES ((`ARR_CONV_TIME_NS + `ARR_CLK_PERIOD_NS - 1) / `ARR_CLK_PERIOD_NS)
`define ARR_QUIET_TIME_NS 475
`define ARR_QUIET_CYCLES ((`ARR_QUIET_TIME_NS + `ARR_CLK_PERIOD_NS - 1) / `ARR_CLK_PERIOD_NS)
`define ARR_RES_BITS 16
`define ARR_FIFO_DEPTH 4
`define ARR_PIN_SERIAL_RESULT_OUT 4
`define ARR_PIN_SCLK 5
`define ARR_PIN_SYNC 6
`define ARR_PIN_RDERR 7
`define ARR_PIN_CFG_DIN 13
`define ARR_PIN_CFG_CLK 14
`define ARR_PIN_CFG_CS 15
`define ARR_CFG_BITS 9
`define ARR_CFG_START_BIT 8
`define ARR_CFG_CODING_BIT 2
`define ARR_HALF_BASE 2
`define ARR_RDC_SLOW_BITS 4
`define ARR_HOST_HALF 3
`define ARR_CNV_LOW 4
`define ARR_PAR_ACCESS 2
`endif

// File: shared/arr_pkg.sv
// state types shared by both ends of the result readout link
package arr_pkg;
  // converter sequencing states
  typedef enum logic [1:0] {
    ARR_IDLE,
    ARR_CONV,
    ARR_PUSH
  } arr_conv_e;
  // host sequencing states
  typedef enum logic [2:0] {
    ARR_H_IDLE,
    ARR_H_CNV,
    ARR_H_WAIT,
    ARR_H_PREAD,
    ARR_H_SREAD
  } arr_host_e;
  // whole state of the converter end
  typedef struct packed {
    logic cnv_prev;
    logic rst_prev;
    arr_conv_e cstate;
    logic [7:0] ccnt;
    logic [15:0] sample;
    logic [15:0] out_word;
    logic [15:0] shreg;
    logic [4:0] bitcnt;
    logic shifting;
    logic [7:0] hcnt;
    logic sclk;
    logic ext_prev;
    logic rderr;
    logic [8:0] cfg;
    logic [8:0] cfg_sh;
    logic [3:0] cfg_cnt;
    logic cfg_clk_prev;
    logic busy;
    logic [15:0] dout;
    logic [15:0] doe;
  } arr_dev_s;
  // whole state of the host end
  typedef struct packed {
    arr_host_e hstate;
    logic [7:0] cnt;
    logic cs_n;
    logic rd_n;
    logic cnv_n;
    logic hclk;
    logic [4:0] nbit;
    logic [15:0] shift;
    logic [4:0] mbit;
    logic [15:0] mshift;
    logic mclk_prev;
    logic [15:0] result;
    logic result_valid;
    logic [15:0] hd;
    logic [15:0] hoe;
  } arr_host_s;
endpackage

// File: shared/arr_link_if.sv
// pins between the converter end and the host end
`timescale 1ns/1ps
interface arr_link_if;
  logic cs_n; // device select, low active
  logic rd_n; // read enable, low active
  logic converter_reset; // high holds the converter in reset
  logic convert_start_n; // falling edge starts a conversion
  logic interface_type_select;
  logic output_coding_select;
  logic byte_order_select;
  logic read_timing_select;
  logic [1:0] clock_divider_select;
  logic clock_source_select;
  logic clock_polarity_invert;
  logic frame_polarity_invert;
  logic busy;
  logic [15:0] host_d;
  logic [15:0] host_oe;
  logic [15:0] dev_d;
  logic [15:0] dev_oe;
  logic [15:0] bus; // resolved data pins, undriven bits read low
  // resolve the shared data pins from both enables
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      bus[i] = dev_oe[i] ? dev_d[i] : (host_oe[i] & host_d[i]);
    end
  end
  modport dev (
    input cs_n, rd_n, converter_reset, convert_start_n, interface_type_select,
    input output_coding_select, byte_order_select, read_timing_select,
    input clock_divider_select, clock_source_select, clock_polarity_invert,
    input frame_polarity_invert, bus,
    output busy, dev_d, dev_oe
  );
  modport host (
    output cs_n, rd_n, converter_reset, convert_start_n, interface_type_select,
    output output_coding_select, byte_order_select, read_timing_select,
    output clock_divider_select, clock_source_select, clock_polarity_invert,
    output frame_polarity_invert, host_d, host_oe,
    input busy, bus
  );
endinterface

// File: design/arr_host.sv
// host end, and the word buffer that sits in the converter's result path
`timescale 1ns/1ps
`include "arr_consts.svh"

// small buffer of words with valid and ready on both sides
module arr_fifo #(
  parameter int WIDTH = `ARR_RES_BITS,
  parameter int DEPTH = `ARR_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  // refuse shapes the pointer logic cannot serve
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad
    $error("arr_fifo needs depth of at least two");
  end
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] count;
  } arr_fifo_s;
  arr_fifo_s s; // registered state
  arr_fifo_s next_s; // next state
  logic push; // word enters this cycle
  logic pop; // word leaves this cycle
  assign in_ready = (s.count != (PW+1)'(DEPTH));
  assign out_valid = (s.count != '0);
  assign out_data = s.mem[s.rd];
  // pointer and count update
  always_comb begin
    next_s = s;
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    if (push) begin
      next_s.mem[s.wr] = in_data;
      next_s.wr = (s.wr == PW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = (s.rd == PW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
    end
    next_s.count = s.count + (PW+1)'(push) - (PW+1)'(pop);
    if (clear) begin
      next_s.wr = '0;
      next_s.rd = '0;
      next_s.count = '0;
    end
  end
  // state register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule // arr_fifo

module arr_host (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic start, // one-cycle request for a conversion and read
  input wire logic reset_request, // level copied to the converter reset pin
  input wire logic serial_mode,
  input wire logic coding_binary,
  input wire logic byte_swap,
  input wire logic read_during,
  input wire logic [1:0] divider,
  input wire logic external_clock,
  input wire logic clock_invert,
  input wire logic frame_invert,
  output logic [15:0] result, // last word read
  output logic result_valid, // one-cycle pulse with result
  arr_link_if.host link
);
  arr_pkg::arr_host_s s; // registered state
  arr_pkg::arr_host_s next_s; // next state
  logic master; // converter makes the clock
  logic mclk; // converter clock, normalised
  logic [15:0] b; // bus copy

  // pins come straight from registers or steady user levels
  assign link.converter_reset = reset_request;
  assign link.interface_type_select = serial_mode;
  assign link.output_coding_select = coding_binary;
  assign link.byte_order_select = byte_swap;
  assign link.read_timing_select = read_during;
  assign link.clock_divider_select = divider;
  assign link.clock_source_select = external_clock;
  assign link.clock_polarity_invert = clock_invert;
  assign link.frame_polarity_invert = frame_invert;
  assign link.cs_n = s.cs_n;
  assign link.rd_n = s.rd_n;
  assign link.convert_start_n = s.cnv_n;
  assign link.host_d = s.hd;
  assign link.host_oe = s.hoe;
  assign result = s.result;
  assign result_valid = s.result_valid;

  // next state of the host
  always_comb begin
    next_s = s;
    next_s.result_valid = 1'b0;
    master = serial_mode & ~external_clock;
    b = link.bus;
    case (s.hstate)
      arr_pkg::ARR_H_IDLE: begin
        if (start) begin
          next_s.hstate = arr_pkg::ARR_H_CNV;
          next_s.cnv_n = 1'b0;
          next_s.cnt = 8'h00;
        end
      end
      arr_pkg::ARR_H_CNV: begin
        next_s.cnt = s.cnt + 8'h01;
        if (s.cnt == 8'(`ARR_CNV_LOW - 1)) begin
          next_s.cnv_n = 1'b1;
          next_s.hstate = master ? arr_pkg::ARR_H_IDLE : arr_pkg::ARR_H_WAIT;
        end
      end
      arr_pkg::ARR_H_WAIT: begin
        // reads wait for busy low, so none lands in a conversion
        if (!link.busy) begin
          next_s.cnt = 8'h00;
          next_s.nbit = 5'h00;
          next_s.cs_n = 1'b0;
          next_s.rd_n = 1'b0;
          next_s.hstate = serial_mode ? arr_pkg::ARR_H_SREAD : arr_pkg::ARR_H_PREAD;
        end
      end
      arr_pkg::ARR_H_PREAD: begin
        // slave parallel read after conversion
        next_s.cnt = s.cnt + 8'h01;
        if (s.cnt == 8'(`ARR_PAR_ACCESS)) begin
          next_s.result = byte_swap ? {b[7:0], b[15:8]} : b;
          next_s.result_valid = 1'b1;
          next_s.cs_n = 1'b1;
          next_s.rd_n = 1'b1;
          next_s.hstate = arr_pkg::ARR_H_IDLE;
        end
      end
      arr_pkg::ARR_H_SREAD: begin
        // slave serial: sixteen clocks, sample at each rise
        next_s.cnt = s.cnt + 8'h01;
        if (s.cnt == 8'(`ARR_HOST_HALF - 1)) begin
          next_s.cnt = 8'h00;
          next_s.hclk = ~s.hclk;
          if (!s.hclk) begin
            next_s.shift = {s.shift[14:0], b[`ARR_PIN_SERIAL_RESULT_OUT]};
            next_s.nbit = s.nbit + 5'h01;
          end else if (s.nbit == 5'(`ARR_RES_BITS)) begin
            next_s.result = s.shift;
            next_s.result_valid = 1'b1;
            next_s.cs_n = 1'b1;
            next_s.rd_n = 1'b1;
            next_s.hstate = arr_pkg::ARR_H_IDLE;
          end
        end
      end
      default: next_s.hstate = arr_pkg::ARR_H_IDLE;
    endcase
    // internal clock mode: select and read stay low, bits taken in frame
    if (master) begin
      next_s.cs_n = 1'b0;
      next_s.rd_n = 1'b0;
    end
    mclk = b[`ARR_PIN_SCLK] ^ clock_invert;
    next_s.mclk_prev = mclk;
    if (~master || ~(b[`ARR_PIN_SYNC] ^ frame_invert)) begin
      next_s.mbit = 5'h00;
    end else if (mclk & ~s.mclk_prev) begin
      next_s.mshift = {s.mshift[14:0], b[`ARR_PIN_SERIAL_RESULT_OUT]};
      next_s.mbit = s.mbit + 5'h01;
      if (s.mbit == 5'(`ARR_RES_BITS - 1)) begin
        next_s.result = {s.mshift[14:0], b[`ARR_PIN_SERIAL_RESULT_OUT]};
        next_s.result_valid = 1'b1;
      end
    end
    // pins the host drives in serial mode: clock when external, and idle config port pins
    next_s.hd = 16'h0000;
    next_s.hoe = 16'h0000;
    if (serial_mode) begin
      next_s.hd[`ARR_PIN_CFG_CS] = 1'b1;
      next_s.hd[`ARR_PIN_CFG_CLK] = clock_invert;
      next_s.hoe[`ARR_PIN_CFG_CS] = 1'b1;
      next_s.hoe[`ARR_PIN_CFG_CLK] = 1'b1;
      next_s.hoe[`ARR_PIN_CFG_DIN] = 1'b1;
      if (external_clock) begin
        next_s.hd[`ARR_PIN_SCLK] = next_s.hclk ^ clock_invert;
        next_s.hoe[`ARR_PIN_SCLK] = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.hstate <= arr_pkg::ARR_H_IDLE;
      s.cs_n <= 1'b1;
      s.rd_n <= 1'b1;
      s.cnv_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
endmodule // arr_host

// File: test/arr_link_assertions.sv
// pin-level checks on the link between converter end and host end
`timescale 1ns/1ps
`include "arr_consts.svh"
module arr_link_assertions (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic converter_reset,
  input wire logic convert_start_n,
  input wire logic interface_type_select,
  input wire logic read_timing_select,
  input wire logic [1:0] clock_divider_select,
  input wire logic clock_source_select,
  input wire logic clock_polarity_invert,
  input wire logic frame_polarity_invert,
  input wire logic busy,
  input wire logic [15:0] dev_oe,
  input wire logic [15:0] bus
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic master; // serial mode with the converter making the clock
  logic sclk; // clock pin with its polarity taken out
  logic frame; // frame strobe with its polarity taken out, only while driven
  logic sclk_oe; // clock pin driven by the converter
  assign master = interface_type_select & ~clock_source_select;
  assign sclk = bus[`ARR_PIN_SCLK] ^ clock_polarity_invert;
  assign frame = (bus[`ARR_PIN_SYNC] ^ frame_polarity_invert) & dev_oe[`ARR_PIN_SYNC];
  assign sclk_oe = dev_oe[`ARR_PIN_SCLK];
  chk_float_deselect: assert property ((cs_n || rd_n) |=> dev_oe == 16'h0000)
    else $error("pins driven while deselected");
  chk_reset_float: assert property (converter_reset |=> dev_oe == 16'h0000 && !busy)
    else $error("pins or busy active in converter reset");
  chk_par_drive: assert property (!interface_type_select && !cs_n && !rd_n && !converter_reset
    |=> dev_oe == 16'hFFFF) else $error("parallel pins not driven");
  chk_busy_start: assert property ($fell(convert_start_n) && !busy && !converter_reset
    |-> ##[0:2] busy) else $error("start edge gave no busy");
  chk_serial_pins: assert property (interface_type_select |-> dev_oe[1:0] == 2'b00)
    else $error("serial mode drives low pins");
  chk_frame_busy: assert property (master && !read_timing_select && frame |-> busy)
    else $error("busy low during frame");
  chk_clock_quiet: assert property (master && sclk_oe && $past(sclk_oe) && !frame
    && !$past(frame) && $stable(clock_polarity_invert) |-> $stable(sclk))
    else $error("serial clock moved outside frame");
  chk_data_steady: assert property (master && frame && $rose(sclk)
    |-> $stable(bus[`ARR_PIN_SERIAL_RESULT_OUT])) else $error("data moved at rising clock");
  chk_half_div0: assert property (master && !read_timing_select && clock_divider_select == 2'b00
    && frame && $rose(sclk) |-> sclk[*2] ##1 !sclk) else $error("half period wrong at 0");
  chk_half_div1: assert property (master && !read_timing_select && clock_divider_select == 2'b01
    && frame && $rose(sclk) |-> sclk[*4] ##1 !sclk) else $error("half period wrong at 1");
  // main scenarios reached
  cov_par_read: cover property (!interface_type_select && dev_oe == 16'hFFFF);
  cov_master_frame: cover property (master && $rose(frame));
  cov_abort: cover property (busy && converter_reset);
endmodule // arr_link_assertions

// File: test/adc_result_readout_interface_tb.sv
// self-checking bench joining both ends of the result readout link
`timescale 1ns/1ps
`define ARR_CHECK(what, exp, got) begin samples_checked++; if ((exp) !== (got)) begin \
  err_count++; $display("wrong value %s expected %h seen %h", what, exp, got); end end
module adc_result_readout_interface_tb;
  logic core_clk = 1'b0; // 100 MHz core clock
  logic rst_b = 1'b0; // async reset, low active
  logic [15:0] conv_data = 16'h0000; // sample fed to the converter
  logic start = 1'b0; // one-cycle request
  logic reset_request = 1'b0; // converter reset level
  logic [8:0] mode = 9'h000; // packed host settings
  logic [15:0] result;
  logic result_valid;
  logic conv_busy;
  logic [15:0] prev_exp = 16'h0000; // word of the previous conversion
  logic [8:0] corner [6] = '{9'h006, 9'h000, 9'h00B, 9'h1C1, 9'h191, 9'h001};
  integer seed = 32'h16f8195b;
  int err_count = 0;
  int samples_checked = 0;
  arr_link_if arr_link_if_inst ();
  arr_device arr_device_inst (.core_clk(core_clk), .rst_b(rst_b), .conv_data(conv_data),
    .conv_busy(conv_busy), .link(arr_link_if_inst));
  arr_host arr_host_inst (.core_clk(core_clk), .rst_b(rst_b), .start(start),
    .reset_request(reset_request), .serial_mode(mode[0]), .coding_binary(mode[1]),
    .byte_swap(mode[2]), .read_during(mode[3]), .divider(mode[5:4]),
    .external_clock(mode[6]), .clock_invert(mode[7]), .frame_invert(mode[8]),
    .result(result), .result_valid(result_valid), .link(arr_link_if_inst));
  arr_link_assertions arr_link_assertions_inst (.core_clk(core_clk), .rst_b(rst_b),
    .cs_n(arr_link_if_inst.cs_n), .rd_n(arr_link_if_inst.rd_n),
    .converter_reset(arr_link_if_inst.converter_reset),
    .convert_start_n(arr_link_if_inst.convert_start_n),
    .interface_type_select(arr_link_if_inst.interface_type_select),
    .read_timing_select(arr_link_if_inst.read_timing_select),
    .clock_divider_select(arr_link_if_inst.clock_divider_select),
    .clock_source_select(arr_link_if_inst.clock_source_select),
    .clock_polarity_invert(arr_link_if_inst.clock_polarity_invert),
    .frame_polarity_invert(arr_link_if_inst.frame_polarity_invert),
    .busy(arr_link_if_inst.busy), .dev_oe(arr_link_if_inst.dev_oe), .bus(arr_link_if_inst.bus));
  // free-running clock
  always #5 core_clk = ~core_clk;
  // straight binary when set, otherwise msb flipped for twos complement
  function automatic logic [15:0] exp_word(input logic [15:0] d, input logic binary);
    exp_word = binary ? d : d ^ 16'h8000;
  endfunction
  // inputs move a fixed delay after the rising edge
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one conversion and read in the present mode
  task automatic transfer(input int idx);
    logic [15:0] exp;
    logic [15:0] exp_pins;
    int n;
    exp = exp_word(conv_data, mode[1]);
    exp_pins = mode[2] ? {exp[7:0], exp[15:8]} : exp;
    start = 1'b1;
    tick();
    start = 1'b0;
    if (!mode[0]) begin
      for (n = 0; n < 600 && !(arr_link_if_inst.dev_oe === 16'hFFFF
          && arr_link_if_inst.busy === 1'b0); n++) tick();
      `ARR_CHECK("parallel drive", 16'hFFFF, arr_link_if_inst.dev_oe)
      `ARR_CHECK("parallel pins", exp_pins, arr_link_if_inst.bus)
    end
    for (n = 0; n < 1200 && result_valid !== 1'b1; n++) tick();
    `ARR_CHECK("result valid", 1'b1, result_valid)
    // read during conversion hands over the previous word
    if (!(mode[3] && idx == 0)) `ARR_CHECK("result word", mode[3] ? prev_exp : exp, result)
    for (n = 0; n < 1200 && arr_link_if_inst.busy !== 1'b0; n++) tick();
    `ARR_CHECK("busy released", 1'b0, arr_link_if_inst.busy)
    repeat (4) tick();
    prev_exp = exp;
  endtask
  // main sequence: corner modes first, then random ones
  initial begin
    repeat (6) @(posedge core_clk);
    #1 rst_b = 1'b1;
    for (int g = 0; g < 8; g++) begin
      // settings change while the converter floats its pins in reset
      reset_request = 1'b1;
      tick();
      mode = g < 6 ? corner[g] : 9'($random(seed));
      if (!mode[0] || mode[6]) mode[3] = 1'b0;
      reset_request = 1'b0;
      tick();
      // in parallel mode abort a conversion with the converter reset
      if (!mode[0]) begin
        start = 1'b1;
        tick();
        start = 1'b0;
        repeat (20) tick();
      end
      reset_request = 1'b1;
      repeat (3) tick();
      `ARR_CHECK("busy in reset", 1'b0, arr_link_if_inst.busy)
      `ARR_CHECK("pins in reset", 16'h0000, arr_link_if_inst.dev_oe)
      reset_request = 1'b0;
      repeat (40) tick();
      for (int t = 0; t < 3; t++) begin
        conv_data = 16'($random(seed));
        if (g == 0) conv_data = 16'h8000 ^ {16{t[0]}};
        transfer(t);
      end
      $display("group %0d done", g);
    end
    close_out();
  end
  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    close_out();
  end
endmodule // adc_result_readout_interface_tb
